// [rtl/fsp_pkg.sv]
// Constants, field layouts and carrier types of the flash status and protection block.
// Assumes a 25 MHz system clock and an SPI command byte sent MSB first.
package fsp_pkg;

    // Command opcodes
    localparam logic [7:0] OPC_ENABLE_WRITES_CMD   = 8'h06;
    localparam logic [7:0] OPC_DISABLE_WRITES_CMD  = 8'h04;
    localparam logic [7:0] OPC_STATUS_READ_CMD     = 8'h05;
    localparam logic [7:0] OPC_STATUS_WRITE_CMD    = 8'h01;
    localparam logic [7:0] OPC_PAGE_PROGRAM        = 8'h02;
    localparam logic [7:0] OPC_SECTOR_ERASE_A      = 8'hd7;
    localparam logic [7:0] OPC_SECTOR_ERASE_B      = 8'h20;
    localparam logic [7:0] OPC_BLOCK_ERASE         = 8'hd8;
    localparam logic [7:0] OPC_WHOLE_ARRAY_ERASE_A = 8'hc7;
    localparam logic [7:0] OPC_WHOLE_ARRAY_ERASE_B = 8'h60;

    // Least whole bytes a command needs before it may act
    localparam logic [2:0] MIN_BYTES_SIMPLE        = 3'h1;
    localparam logic [2:0] MIN_BYTES_STATUS_WRITE  = 3'h2;
    localparam logic [2:0] MIN_BYTES_ERASE         = 3'h4;
    localparam logic [2:0] MIN_BYTES_PROGRAM       = 3'h5;
    localparam logic [2:0] BYTE_COUNT_MAX          = 3'h7;
    localparam logic [2:0] BIT_PHASE_LAST          = 3'h7;

    // Protection map
    localparam logic [23:0] ARRAY_TOP_ADDR         = 24'h007fff;
    localparam logic [1:0]  LEVEL_ALL_PROTECTED    = 2'h3;

    // Reset and delivered values
    localparam logic [7:0] STATUS_RESET            = 8'h00;
    localparam logic [2:0] LEVEL_DELIVERED         = 3'h0;
    localparam logic       LOCK_DELIVERED          = 1'b0;

    // Status write cycle time
    localparam int         CLK_PERIOD_NS           = 40;
    localparam int         STATUS_WRITE_TIME_NS    = 10000;
    localparam logic [7:0] STATUS_WRITE_CYCLES     =
        8'((STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Status byte layout, bit 7 down to bit 0
    typedef struct packed {
        logic       status_lock;
        logic [1:0] reserved;
        logic [2:0] protect_level;
        logic       write_enable_latch;
        logic       busy_flag;
    } fsp_status_t;

    // Words gathered from one frame on the link
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] byte1;
        logic [7:0] byte2;
        logic [7:0] byte3;
        logic [2:0] bit_phase;
        logic [2:0] byte_count;
    } fsp_frame_t;

    // Operation handed to the array engine
    typedef enum logic [1:0] {
        FSP_OP_PROGRAM,
        FSP_OP_SECTOR_ERASE,
        FSP_OP_BLOCK_ERASE,
        FSP_OP_WHOLE_ERASE
    } fsp_op_t;

    // Busy state of the write control
    typedef enum logic [1:0] {
        FSP_ST_IDLE,
        FSP_ST_ARRAY,
        FSP_ST_STATUS
    } fsp_state_t;

endpackage

// [rtl/fsp_sync.sv]
// Two flip-flop level synchroniser, two stages per bit.
// Assumes inputs are levels that stay stable for several clock periods.
`timescale 1ns/100ps
module fsp_sync #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // Levels
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta_reg <= RESET_VAL;
            sync_reg <= RESET_VAL;
        end else begin
            meta_reg <= din;
            sync_reg <= meta_reg;
        end
    end

    assign dout = sync_reg;
endmodule // fsp_sync

// [rtl/fsp_status_protect.sv]
// Status register and write protection of a small serial flash behind an SPI link.
// Assumes sck clocks only while cs_n is low and an array engine that pulses op_done.
`timescale 1ns/100ps
// Function
// [RULE1] Lock, level bits kept; changed by status write
// [RULE2] Delivered with level and lock bits zero
// [RULE3] Bit 0 reads busy during write cycles
// [RULE4] Latch clear ignores every write command
// [RULE5] Enable-writes command sets the latch
// [RULE6] Disable-writes command clears the latch
// [RULE7] Latch clears when a write cycle completes
// [RULE8] Levels one and zero set protect whole array
// [RULE9] Protected targets refuse program and erase
// [RULE10] Whole erase only with all levels zero
// [RULE11] Lock with pin low blocks status writes
// [RULE12] Writes need clock count multiple of eight
// [RULE13] Status byte layout, reserved bits read zero
// [RULE14] While busy only status read is served
// [RULE15] Latch starts cleared after power-up
// [RULE16] Busy set at start, cleared with latch
module fsp_status_protect (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         resetn,
    // Serial link
    input  wire logic         sck,
    input  wire logic         cs_n,
    input  wire logic         mosi,
    output logic              miso,
    output logic              miso_oe,
    // Write protect pin
    input  wire logic         wp_n,
    // Load of delivered non-volatile values
    input  wire logic         factory_init,
    // Array engine
    output logic              op_start,
    output fsp_pkg::fsp_op_t  op_kind,
    output logic [23:0]       op_addr,
    input  wire logic         op_done,
    // Status view
    output fsp_pkg::fsp_status_t protection_status
);

    // ---------------- Link side, clocked by sck ----------------
    logic                 fresh_reg;
    logic [7:0]           shift_reg;
    fsp_pkg::fsp_frame_t  frame_reg;
    fsp_pkg::fsp_frame_t  frame_next;
    logic [7:0]           out_reg;
    logic [7:0]           status_hold_reg;
    wire  [2:0]           phase_cur  = fresh_reg ? 3'h0 : frame_reg.bit_phase;
    wire  [2:0]           count_cur  = fresh_reg ? 3'h0 : frame_reg.byte_count;
    wire                  byte_done  = (phase_cur == fsp_pkg::BIT_PHASE_LAST);
    wire  [7:0]           byte_in    = {shift_reg[6:0], mosi};
    wire                  out_load   = !fresh_reg && (frame_reg.bit_phase == 3'h0) &&
                                       (frame_reg.byte_count != 3'h0);
    wire                  read_frame = (frame_reg.opcode == fsp_pkg::OPC_STATUS_READ_CMD);

    // Marks the first rising edge of a frame; set by deselect, cleared by the first rising sck
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            fresh_reg <= 1'b1;
        end else begin
            fresh_reg <= 1'b0;
        end
    end

    // Bit and byte counting, bytes filed by position in the frame
    always_comb begin
        frame_next           = frame_reg;
        frame_next.bit_phase = phase_cur + 3'h1;
        frame_next.byte_count = count_cur;
        if (byte_done) begin
            case (count_cur)
                3'h0: frame_next.opcode = byte_in;
                3'h1: frame_next.byte1  = byte_in;
                3'h2: frame_next.byte2  = byte_in;
                3'h3: frame_next.byte3  = byte_in;
                default: frame_next.opcode = frame_reg.opcode;
            endcase
            if (count_cur != fsp_pkg::BYTE_COUNT_MAX) begin
                frame_next.byte_count = count_cur + 3'h1;
            end
        end
    end

    // Capture on rising sck; words stay put after the frame for the system side
    always_ff @(posedge sck) begin
        shift_reg <= byte_in;
        frame_reg <= frame_next;
    end

    // Status byte shifted out on falling sck, reloaded at each byte boundary
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            out_reg <= fsp_pkg::STATUS_RESET;
        end else if (out_load) begin
            out_reg <= status_hold_reg;
        end else begin
            out_reg <= {out_reg[6:0], 1'b0};
        end
    end

    // Output drives only during a status read after its opcode byte
    assign miso    = out_reg[7];
    assign miso_oe = !cs_n && !fresh_reg && read_frame && (frame_reg.byte_count != 3'h0);

    // ---------------- System side, clocked by mclk ----------------
    logic                 cs_idle;
    logic                 wp_n_s;
    logic                 cs_idle_d_reg;
    fsp_pkg::fsp_state_t  state_reg;
    fsp_pkg::fsp_state_t  state_next;
    logic                 wel_reg;
    logic                 wel_next;
    logic                 lock_reg;
    logic [2:0]           level_reg;
    logic [7:0]           timer_reg;
    logic                 op_start_reg;
    fsp_pkg::fsp_op_t     op_kind_reg;
    logic [23:0]          op_addr_reg;
    fsp_pkg::fsp_status_t status_now;
    fsp_pkg::fsp_status_t status_wr;

    // Deselect and write-protect pins into the system clock
    fsp_sync #(
        .WIDTH     (2),
        .RESET_VAL (2'h3)
    ) u_pin_sync (
        .clk    (mclk),
        .resetn (resetn),
        .din    ({cs_n, wp_n}),
        .dout   ({cs_idle, wp_n_s})
    );

    // End of frame seen once link words are static
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cs_idle_d_reg <= 1'b1;
        end else begin
            cs_idle_d_reg <= cs_idle;
        end
    end

    // Command decode of the finished frame
    wire        frame_end  = cs_idle && !cs_idle_d_reg;
    wire [7:0]  opc        = frame_reg.opcode;
    wire [2:0]  nbytes     = frame_reg.byte_count;
    wire        whole      = (frame_reg.bit_phase == 3'h0);
    wire        idle       = (state_reg == fsp_pkg::FSP_ST_IDLE);
    wire [23:0] tgt_addr   = {frame_reg.byte1, frame_reg.byte2, frame_reg.byte3};
    wire        is_enable_writes_cmd    = (opc == fsp_pkg::OPC_ENABLE_WRITES_CMD);
    wire        is_disable_writes_cmd    = (opc == fsp_pkg::OPC_DISABLE_WRITES_CMD);
    wire        is_status_write_cmd    = (opc == fsp_pkg::OPC_STATUS_WRITE_CMD);
    wire        is_prog    = (opc == fsp_pkg::OPC_PAGE_PROGRAM);
    wire        is_sector  = (opc == fsp_pkg::OPC_SECTOR_ERASE_A) ||
                             (opc == fsp_pkg::OPC_SECTOR_ERASE_B);
    wire        is_block   = (opc == fsp_pkg::OPC_BLOCK_ERASE);
    wire        is_whole   = (opc == fsp_pkg::OPC_WHOLE_ARRAY_ERASE_A) ||
                             (opc == fsp_pkg::OPC_WHOLE_ARRAY_ERASE_B);

    // Protection checks
    wire        in_prot    = (level_reg[1:0] == fsp_pkg::LEVEL_ALL_PROTECTED) &&
                             (tgt_addr <= fsp_pkg::ARRAY_TOP_ADDR);        // RULE8
    wire        sr_locked  = lock_reg && !wp_n_s;                          // RULE11
    wire        cmd_ok     = frame_end && idle;                            // RULE14
    wire        can_write  = cmd_ok && wel_reg && whole;                   // RULE4 RULE12

    // Accepted operations
    wire        enable_writes_cmd_go    = cmd_ok && is_enable_writes_cmd && (nbytes >= fsp_pkg::MIN_BYTES_SIMPLE);
    wire        disable_writes_cmd_go    = cmd_ok && is_disable_writes_cmd && (nbytes >= fsp_pkg::MIN_BYTES_SIMPLE);
    wire        status_write_cmd_go    = can_write && is_status_write_cmd && !sr_locked &&
                             (nbytes >= fsp_pkg::MIN_BYTES_STATUS_WRITE);  // RULE11
    wire        prog_go    = can_write && is_prog && !in_prot &&
                             (nbytes >= fsp_pkg::MIN_BYTES_PROGRAM);       // RULE9
    wire        erase_go   = can_write && (is_sector || is_block) && !in_prot &&
                             (nbytes >= fsp_pkg::MIN_BYTES_ERASE);         // RULE9
    wire        whole_go   = can_write && is_whole && (level_reg == 3'h0) &&
                             (nbytes >= fsp_pkg::MIN_BYTES_SIMPLE);        // RULE10
    wire        array_go   = prog_go || erase_go || whole_go;
    wire        done       = ((state_reg == fsp_pkg::FSP_ST_ARRAY) && op_done) ||
                             ((state_reg == fsp_pkg::FSP_ST_STATUS) && (timer_reg == 8'h0));
    wire        st_status  = (state_reg == fsp_pkg::FSP_ST_STATUS);

    // Busy sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            fsp_pkg::FSP_ST_IDLE: begin
                if (status_write_cmd_go) begin
                    state_next = fsp_pkg::FSP_ST_STATUS;   // RULE16
                end else if (array_go) begin
                    state_next = fsp_pkg::FSP_ST_ARRAY;    // RULE16
                end
            end
            fsp_pkg::FSP_ST_ARRAY,
            fsp_pkg::FSP_ST_STATUS: begin
                if (done) begin
                    state_next = fsp_pkg::FSP_ST_IDLE;     // RULE16
                end
            end
            default: state_next = fsp_pkg::FSP_ST_IDLE;
        endcase
    end

    // Write enable latch: set, cleared by command or by completion
    always_comb begin
        wel_next = wel_reg;
        if (done) begin
            wel_next = 1'b0;                               // RULE7
        end else if (enable_writes_cmd_go) begin
            wel_next = 1'b1;                               // RULE5
        end else if (disable_writes_cmd_go) begin
            wel_next = 1'b0;                               // RULE6
        end
    end

    // Control state, latch cleared at reset
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_reg <= fsp_pkg::FSP_ST_IDLE;
            wel_reg   <= 1'b0;                             // RULE15
            timer_reg <= 8'h0;
        end else begin
            state_reg <= state_next;
            wel_reg   <= wel_next;
            timer_reg <= status_write_cmd_go ? (fsp_pkg::STATUS_WRITE_CYCLES - 8'h1) :
                         (timer_reg != 8'h0) ? (timer_reg - 8'h1) : 8'h0;
        end
    end

    // Non-volatile cells: untouched by reset, loaded only by factory_init or a status write
    assign status_wr = fsp_pkg::fsp_status_t'(frame_reg.byte1);
    always_ff @(posedge mclk) begin
        if (factory_init) begin
            lock_reg  <= fsp_pkg::LOCK_DELIVERED;          // RULE2
            level_reg <= fsp_pkg::LEVEL_DELIVERED;         // RULE2
        end else if (status_write_cmd_go) begin
            lock_reg  <= status_wr.status_lock;            // RULE1
            level_reg <= status_wr.protect_level;          // RULE1
        end
    end

    // Request to the array engine
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            op_start_reg <= 1'b0;
            op_kind_reg  <= fsp_pkg::FSP_OP_PROGRAM;
            op_addr_reg  <= 24'h0;
        end else begin
            op_start_reg <= array_go;
            if (array_go) begin
                op_addr_reg <= tgt_addr;
                op_kind_reg <= prog_go   ? fsp_pkg::FSP_OP_PROGRAM :
                               is_sector ? fsp_pkg::FSP_OP_SECTOR_ERASE :
                               is_block  ? fsp_pkg::FSP_OP_BLOCK_ERASE :
                                           fsp_pkg::FSP_OP_WHOLE_ERASE;
            end
        end
    end

    // Status byte assembly
    always_comb begin
        status_now                    = fsp_pkg::fsp_status_t'(fsp_pkg::STATUS_RESET);
        status_now.status_lock        = lock_reg;
        status_now.protect_level      = level_reg;
        status_now.write_enable_latch = wel_reg;
        status_now.busy_flag          = !idle;             // RULE3
    end

    // Copy for the link, frozen while a frame runs
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            status_hold_reg <= fsp_pkg::STATUS_RESET;
        end else if (cs_idle) begin
            status_hold_reg <= status_now;                 // RULE13
        end
    end

    assign op_start          = op_start_reg;
    assign op_kind           = op_kind_reg;
    assign op_addr           = op_addr_reg;
    assign protection_status = status_now;

    // ---------------- Checks ----------------
    localparam int SW_CYC = 250;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    chk_status_bit_layout: assert property ( // RULE13
        (protection_status.reserved == 2'h0) && (protection_status.busy_flag == !idle))
        else $error("status byte layout wrong");
    chk_busy_reports_cycle: assert property ( // RULE3
        op_start |-> protection_status.busy_flag)
        else $error("busy flag low during array cycle");
    chk_latch_gates_write: assert property ( // RULE4
        frame_end && !wel_reg && idle |=> !op_start && (state_reg == fsp_pkg::FSP_ST_IDLE))
        else $error("write accepted with latch clear");
    chk_enable_sets_latch: assert property ( // RULE5
        frame_end && idle && (opc == 8'h06) && (nbytes != 3'h0) |=> wel_reg)
        else $error("enable writes did not set latch");
    chk_disable_clears: assert property ( // RULE6
        frame_end && idle && (opc == 8'h04) && (nbytes != 3'h0) |=> !wel_reg)
        else $error("disable writes did not clear latch");
    chk_done_clears_latch: assert property ( // RULE7
        $fell(protection_status.busy_flag) |-> !wel_reg && $past(wel_reg))
        else $error("latch not cleared at completion");
    chk_protected_target: assert property ( // RULE9
        op_start |-> !((level_reg[1:0] == 2'h3) && (op_addr <= 24'h007fff)))
        else $error("operation started in protected area");
    chk_whole_erase_gate: assert property ( // RULE10
        op_start && (op_kind == fsp_pkg::FSP_OP_WHOLE_ERASE) |-> (level_reg == 3'h0))
        else $error("whole erase with levels set");
    chk_lock_holds_bits: assert property ( // RULE11
        frame_end && idle && lock_reg && !wp_n_s && !factory_init |=>
            $stable(level_reg) && $stable(lock_reg) && !st_status)
        else $error("locked status register changed");
    chk_partial_byte_drop: assert property ( // RULE12
        frame_end && (frame_reg.bit_phase != 3'h0) && idle |=>
            !op_start && (state_reg == fsp_pkg::FSP_ST_IDLE))
        else $error("partial byte frame executed");
    chk_busy_ignores_cmds: assert property ( // RULE14
        frame_end && !idle && !done |=> $stable(wel_reg) && !op_start)
        else $error("command taken while busy");
    chk_status_cycle_len: assert property ( // RULE16
        $rose(st_status) |-> ##SW_CYC (!st_status && !wel_reg))
        else $error("status write cycle length wrong");

endmodule // fsp_status_protect

// [dv/fsp_host_model.sv]
// Behavioural SPI host in mode 0 that frames commands for the status and protection block.
// Assumes the bench resolves miso from miso_oe and calls frame() from one process only.
`timescale 1ns/100ps
module fsp_host_model (
    // Serial link
    output logic      sck,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso
);
    // Idle link: clock parked low, chip deselected
    initial begin
        sck  = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // One frame, MSB first, 64 ns per bit; the clock runs only inside the frame
    task automatic frame(input logic [39:0] data, input int nbits, output logic [7:0] rx);
        int i;
        rx = 8'h00;
        cs_n = 1'b0;
        #32;
        for (i = 0; i < nbits; i++) begin
            mosi = data[39-i];
            #32 sck = 1'b1;
            rx = {rx[6:0], miso};
            #32 sck = 1'b0;
        end
        #32 cs_n = 1'b1;
        mosi = ~mosi; // Released line must not keep the last bit
        #400; // Deselect gap well beyond four system clocks
    endtask
endmodule // fsp_host_model

// [dv/flash_status_write_protect_bench.sv]
// Self-checking bench of the flash status and write-protection block.
// Assumes a 25 MHz system clock, a behavioural SPI host and an array engine played here.
`timescale 1ns/100ps
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[ERR] %s expected %h seen %h", what, exp, got); end end
module flash_status_write_protect_bench;
    // Table row: pin level, command bits, status after frame, start, kind, final status
    typedef struct packed {
        logic        wp;
        logic [39:0] cmd;
        logic [5:0]  nbits;
        logic [7:0]  mid;
        logic        st;
        logic [1:0]  kind;
        logic [7:0]  fin;
    } fsp_row_t;

    logic                  mclk, resetn, sck, cs_n, mosi, miso, miso_oe, miso_w;
    logic                  wp_n, factory_init, op_start, op_done;
    fsp_pkg::fsp_op_t      op_kind;
    fsp_pkg::fsp_status_t  protection_status;
    logic [23:0]           op_addr;
    logic [23:0]           last_addr;
    logic [1:0]            last_kind;
    logic [7:0]            rx;
    int                    n_mismatch, n_compared, n_start, r;

    // Ordinary cases, run in order; the state carries from row to row
    fsp_row_t rows [28] = '{
        '{1'b1, 40'h0600000000, 6'h08, 8'h02, 1'b0, 2'h0, 8'h02},
        '{1'b1, 40'h0400000000, 6'h08, 8'h00, 1'b0, 2'h0, 8'h00},
        '{1'b1, 40'h019c000000, 6'h10, 8'h00, 1'b0, 2'h0, 8'h00},
        '{1'b1, 40'h0600000000, 6'h08, 8'h02, 1'b0, 2'h0, 8'h02},
        '{1'b1, 40'h019c000000, 6'h0f, 8'h02, 1'b0, 2'h0, 8'h02},
        '{1'b1, 40'h010c000000, 6'h10, 8'h0f, 1'b0, 2'h0, 8'h0c},
        '{1'b1, 40'h0600000000, 6'h08, 8'h0e, 1'b0, 2'h0, 8'h0e},
        '{1'b1, 40'h02000100a5, 6'h28, 8'h0e, 1'b0, 2'h0, 8'h0e},
        '{1'b1, 40'h0200800000, 6'h20, 8'h0e, 1'b0, 2'h0, 8'h0e},
        '{1'b1, 40'hc700000000, 6'h08, 8'h0e, 1'b0, 2'h0, 8'h0e},
        '{1'b1, 40'h0180000000, 6'h10, 8'h83, 1'b0, 2'h0, 8'h80},
        '{1'b1, 40'h0600000000, 6'h08, 8'h82, 1'b0, 2'h0, 8'h82},
        '{1'b0, 40'h011c000000, 6'h10, 8'h82, 1'b0, 2'h0, 8'h82},
        '{1'b1, 40'h0100000000, 6'h10, 8'h03, 1'b0, 2'h0, 8'h00},
        '{1'b0, 40'h0600000000, 6'h08, 8'h02, 1'b0, 2'h0, 8'h02},
        '{1'b0, 40'h02000100a5, 6'h28, 8'h03, 1'b1, 2'h0, 8'h00},
        '{1'b1, 40'h0600000000, 6'h08, 8'h02, 1'b0, 2'h0, 8'h02},
        '{1'b1, 40'h2000800000, 6'h20, 8'h03, 1'b1, 2'h1, 8'h00},
        '{1'b1, 40'h0600000000, 6'h08, 8'h02, 1'b0, 2'h0, 8'h02},
        '{1'b1, 40'hd800100000, 6'h20, 8'h03, 1'b1, 2'h2, 8'h00},
        '{1'b1, 40'h0600000000, 6'h08, 8'h02, 1'b0, 2'h0, 8'h02},
        '{1'b1, 40'h6000000000, 6'h08, 8'h03, 1'b1, 2'h3, 8'h00},
        '{1'b1, 40'h0600000000, 6'h08, 8'h02, 1'b0, 2'h0, 8'h02},
        '{1'b1, 40'h0110000000, 6'h10, 8'h13, 1'b0, 2'h0, 8'h10},
        '{1'b1, 40'h0600000000, 6'h08, 8'h12, 1'b0, 2'h0, 8'h12},
        '{1'b1, 40'h02000100a5, 6'h28, 8'h13, 1'b1, 2'h0, 8'h10},
        '{1'b1, 40'h0600000000, 6'h08, 8'h12, 1'b0, 2'h0, 8'h12},
        '{1'b1, 40'hc700000000, 6'h08, 8'h12, 1'b0, 2'h0, 8'h12}
    };

    // Device, host model, and miso wire that shows the inverse when undriven
    fsp_status_protect dut_u (.mclk(mclk), .resetn(resetn), .sck(sck), .cs_n(cs_n),
        .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .wp_n(wp_n),
        .factory_init(factory_init), .op_start(op_start), .op_kind(op_kind),
        .op_addr(op_addr), .op_done(op_done), .protection_status(protection_status));
    fsp_host_model host_u (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso_w));
    assign miso_w = miso_oe ? miso : ~miso;

    // Clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Count array requests and keep the last kind
    always @(posedge mclk) begin
        if (op_start === 1'b1) begin
            n_start <= n_start + 1;
            last_kind <= op_kind;
            last_addr <= op_addr;
        end
    end

    // Wait for the busy flag to drop, bounded
    task automatic wait_idle();
        int k;
        for (k = 0; k < 400 && protection_status.busy_flag !== 1'b0; k++) @(posedge mclk);
        #1;
    endtask

    // One table row: frame, settle, check, finish the operation, check again
    task automatic do_row(input fsp_row_t w);
        int s0;
        s0 = n_start;
        @(posedge mclk) #1 wp_n = w.wp;
        host_u.frame(w.cmd, int'(w.nbits), rx);
        @(posedge mclk) #1;
        `CHK("status", w.mid, protection_status)
        `CHK("op_start", w.st, 1'(n_start != s0))
        if (w.st) `CHK("op_kind", w.kind, last_kind)
        if (w.st && w.kind != 2'h3) `CHK("op_addr", w.cmd[31:8], last_addr)
        if (w.st) begin
            op_done = 1'b1;
            @(posedge mclk) #1 op_done = 1'b0;
        end
        wait_idle();
        `CHK("final status", w.fin, protection_status)
    endtask

    task automatic complete_run();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog
    initial begin
        #2000000;
        n_mismatch++;
        complete_run();
    end

    // Main sequence
    initial begin
        {resetn, op_done, n_mismatch, n_compared} = '0;
        wp_n = 1'b1;
        factory_init = 1'b1;
        repeat (5) @(posedge mclk);
        #1 resetn = 1'b1;
        factory_init = 1'b0;
        repeat (3) @(posedge mclk);
        #1 `CHK("delivered", 8'h00, protection_status)
        for (r = 0; r < 28; r++) do_row(rows[r]);
        // Reset mid-run: latch drops, non-volatile bits stay
        @(posedge mclk) #1 resetn = 1'b0;
        repeat (5) @(posedge mclk);
        #1 resetn = 1'b1;
        repeat (3) @(posedge mclk);
        #1 `CHK("after reset", 8'h10, protection_status)
        host_u.frame(40'h0500000000, 16, rx);
        `CHK("serial status", 8'h10, rx)
        `CHK("released oe", 1'b0, miso_oe)
        // Commands during a busy cycle are ignored except status read
        do_row('{1'b1, 40'h0600000000, 6'h08, 8'h12, 1'b0, 2'h0, 8'h12});
        host_u.frame(40'h0100000000, 16, rx);
        host_u.frame(40'h0400000000, 8, rx);
        host_u.frame(40'h0500000000, 16, rx);
        `CHK("busy read", 8'h03, rx)
        wait_idle();
        `CHK("idle", 8'h00, protection_status)
        complete_run();
    end
endmodule // flash_status_write_protect_bench
